// file: verilog/sfb_pkg.sv
// shared constants for the feedback pulse and torque cap block
package sfb_pkg;
	// 4-bit word addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_GEAR_NUM = 4'h1;
	localparam logic [3:0] ADDR_GEAR_DEN = 4'h2;
	localparam logic [3:0] ADDR_VEL_GAIN = 4'h3;
	localparam logic [3:0] ADDR_VEL_ITIME = 4'h4;
	localparam logic [3:0] ADDR_TQ_FILT = 4'h5;
	localparam logic [3:0] ADDR_CUR_BW = 4'h6;
	localparam logic [3:0] ADDR_TQ_CAP = 4'h7;
	localparam logic [3:0] ADDR_RATED_CUR = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'h9;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'hA;
	localparam logic [3:0] ADDR_IRQ_CLR = 4'hB;
	localparam logic [3:0] ADDR_IRQ_EN = 4'hC;
	// control field positions
	localparam int CTRL_FMT_LO = 0;
	localparam int CTRL_NEG = 4;
	localparam int CTRL_EN = 5;
	localparam int CTRL_SERIAL = 6;
	// feedback format codes
	localparam logic [1:0] FMT_QUAD = 2'h0;
	localparam logic [1:0] FMT_PULSE_SIGN = 2'h1;
	localparam logic [1:0] FMT_FWD_REV = 2'h2;
	// reset values
	localparam logic [6:0] CTRL_RESET = 7'h20;
	localparam logic [15:0] GEAR_RESET = 16'h0001;
	localparam logic [15:0] VEL_GAIN_RESET = 16'h0064;
	localparam logic [15:0] VEL_ITIME_RESET = 16'h0014;
	localparam logic [15:0] TQ_FILT_RESET = 16'h0000;
	localparam logic [15:0] CUR_BW_RESET = 16'h07D0;
	localparam logic [15:0] RATED_CUR_RESET = 16'h03E8;
	// accepted ranges; cap factor in hundredths, filter in 10 us units
	localparam logic [15:0] VEL_GAIN_MIN = 16'h000A;
	localparam logic [15:0] VEL_GAIN_MAX = 16'h2710;
	localparam logic [15:0] VEL_ITIME_MAX = 16'h03E8;
	localparam logic [15:0] TQ_FILT_MAX = 16'h7FFF;
	localparam logic [15:0] CUR_BW_MIN = 16'h01F4;
	localparam logic [15:0] CUR_BW_MAX = 16'h7FFF;
	localparam logic [15:0] TQ_CAP_MIN = 16'h0001;
	localparam logic [15:0] TQ_CAP_MAX = 16'h0046;
	localparam logic [15:0] TQ_CAP_RESET = 16'h0046;
	localparam logic [22:0] TQ_CAP_SCALE = 23'h00_0064;
	// serial encoder index window and speed bound
	localparam logic [15:0] INDEX_HALF_WIN = 16'h005B;
	localparam logic [15:0] INDEX_SPEED_MAX = 16'h0064;
	// interrupt bits
	localparam int IRQ_CAP = 0;
	localparam int IRQ_INDEX = 1;
	localparam int IRQ_FAST = 2;
	localparam int IRQ_RANGE = 3;
endpackage : sfb_pkg

// file: verilog/sfb_gear.sv
// electronic gear: rescales motor steps by numerator over denominator
`timescale 1ns/1ps
`default_nettype none
module sfb_gear (
	input wire logic clk,
	input wire logic rstn,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic [15:0] gear_num,
	input wire logic [15:0] gear_den,
	input wire logic sink_busy,
	output logic step_out,
	output logic dir_out
);
	// whole state of the scaler
	typedef struct packed {
		logic [16:0] acc; // residue of scaled steps
		logic dir; // direction of pending steps
		logic step; // step pulse toward the formatter
	} sfb_gear_t;
	sfb_gear_t st, next_st;

	// add num per step, pay one step per den
	always_comb begin
		next_st = st;
		next_st.step = 1'b0;
		if (step_in) begin
			// reversal drops the old residue
			if (dir_in != st.dir) begin
				next_st.acc = {1'b0, gear_num};
			end else begin
				next_st.acc = st.acc + {1'b0, gear_num};
			end
			next_st.dir = dir_in;
		end
		// paced by the formatter; a reversal pays out a cycle later
		if (!sink_busy && !st.step && (st.acc >= {1'b0, gear_den}) &&
			(gear_den != 16'h0000) && !(step_in && (dir_in != st.dir))) begin
			next_st.acc = next_st.acc - {1'b0, gear_den};
			next_st.step = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign step_out = st.step;
	assign dir_out = st.dir;
endmodule : sfb_gear
`default_nettype wire

// file: verilog/sfb_pulse_fmt.sv
// turns scaled steps into quadrature, pulse/sign or fwd/rev trains
`timescale 1ns/1ps
`default_nettype none
module sfb_pulse_fmt (
	input wire logic clk,
	input wire logic rstn,
	input wire logic step,
	input wire logic dir,
	input wire logic [1:0] fmt,
	output logic busy,
	output logic chan_a,
	output logic chan_b
);
	// whole state of the formatter
	typedef struct packed {
		logic [1:0] phase; // quadrature gray position
		logic pulse; // pulse high phase of a train
		logic a;
		logic b;
	} sfb_fmt_t;
	sfb_fmt_t st, next_st;

	// one step, one edge; trains need a low cycle
	always_comb begin
		next_st = st;
		next_st.pulse = 1'b0;
		case (fmt)
			sfb_pkg::FMT_QUAD: begin
				// four edges per cycle, phase order gives direction
				if (step) begin
					next_st.phase = dir ? st.phase + 2'd1 : st.phase - 2'd1;
				end
				next_st.a = next_st.phase[1];
				next_st.b = next_st.phase[1] ^ next_st.phase[0];
			end
			sfb_pkg::FMT_PULSE_SIGN: begin
				next_st.pulse = step;
				next_st.a = step;
				next_st.b = step ? dir : st.b;
			end
			sfb_pkg::FMT_FWD_REV: begin
				next_st.pulse = step;
				next_st.a = step && dir;
				next_st.b = step && !dir;
			end
			default: begin
				// unused code leaves both channels idle
				next_st.a = 1'b0;
				next_st.b = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.pulse;
	assign chan_a = st.a;
	assign chan_b = st.b;
endmodule : sfb_pulse_fmt
`default_nettype wire

// file: verilog/sfb_top.sv
// servo feedback pulse output, torque cap and loop setting registers
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - incremental encoder index passes straight to marker
// - serial encoder marks within half degree of home
// - marker accuracy only up to 100 rpm
// - feedback uses the command electronic gear ratio
// - enable flag cleared suppresses every feedback output
// - cap factor 0.01 to 0.70, default 0.70
// - clamp torque only while cap select asserted
// - flag when torque current reaches cap current
// - velocity gain accepted from 10 to 10000
// - velocity integral time 0 to 1000 ms
// - torque filter time 0.00 to 327.67 ms
// - current bandwidth held within 500 to 32767
// - quadrature channels ninety degrees, order gives direction
// - forward pulses on a, reverse on b
module sfb_top (
	input wire logic clk,
	input wire logic rstn,
	// software register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// motor steps, same clock
	input wire logic motor_step,
	input wire logic motor_dir,
	// serial encoder angle (full turn = 65536) and speed in rpm
	input wire logic [15:0] mech_angle,
	input wire logic [15:0] motor_speed_rpm,
	// incremental index pin, asynchronous
	input wire logic enc_index_in,
	// torque path
	input wire logic torque_cap_select_in,
	input wire logic [15:0] torque_current,
	input wire logic signed [15:0] torque_cmd_in,
	output logic signed [15:0] torque_cmd_out,
	output logic torque_capping_flag_out,
	// feedback pairs toward the host
	output logic feedback_channel_a,
	output logic feedback_channel_a_n,
	output logic feedback_channel_b,
	output logic feedback_channel_b_n,
	output logic feedback_index_marker,
	output logic feedback_index_marker_n,
	// loop settings
	output logic [15:0] velocity_loop_gain,
	output logic [15:0] velocity_integral_time,
	output logic [15:0] torque_cmd_filter_time,
	output logic [15:0] current_loop_bandwidth,
	output logic irq
);
	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [6:0] ctrl; // format, logic, enable, encoder kind
		logic [15:0] gear_num;
		logic [15:0] gear_den;
		logic [15:0] vel_gain;
		logic [15:0] vel_itime;
		logic [15:0] tq_filt;
		logic [15:0] cur_bw;
		logic [15:0] tq_cap; // hundredths of rated current
		logic [15:0] rated_cur;
		logic [3:0] irq_stat; // sticky events
		logic [3:0] irq_en;
		logic [15:0] rdata;
		logic [1:0] idx_sync; // index pin synchroniser
		logic [1:0] sel_sync; // cap select synchroniser
		logic idx_prev; // marker for edge event
		logic cap_prev; // capping flag for edge event
		logic fast_prev; // overspeed for edge event
		logic fa;
		logic fa_n;
		logic fb;
		logic fb_n;
		logic fz;
		logic fz_n;
		logic cap_flag;
		logic signed [15:0] tq_out;
		logic irq;
	} sfb_state_t;
	sfb_state_t st, next_st;

	logic gear_step; // scaled step
	logic gear_dir; // direction of scaled step
	logic fmt_busy; // formatter still in a pulse
	logic fmt_a; // raw channel a
	logic fmt_b; // raw channel b
	logic [22:0] cap_product; // rated current times cap factor
	logic [15:0] cap_current; // current that marks the cap
	logic index_win; // serial angle near home
	logic index_raw; // marker before enable and polarity
	logic speed_fast; // marker placement not guaranteed
	logic range_hit; // a write was brought into range
	logic [3:0] events; // one-cycle event pulses

	////////////////////////////////////////////////////////////////////
	// feedback pulse path

	// command gear rescales steps
	sfb_gear u_gear (
		.clk(clk),
		.rstn(rstn),
		.step_in(motor_step),
		.dir_in(motor_dir),
		.gear_num(st.gear_num),
		.gear_den(st.gear_den),
		.sink_busy(fmt_busy),
		.step_out(gear_step),
		.dir_out(gear_dir)
	);

	// train shaping by the selected format
	sfb_pulse_fmt u_fmt (
		.clk(clk),
		.rstn(rstn),
		.step(gear_step),
		.dir(gear_dir),
		.fmt(st.ctrl[sfb_pkg::CTRL_FMT_LO +: 2]),
		.busy(fmt_busy),
		.chan_a(fmt_a),
		.chan_b(fmt_b)
	);

	////////////////////////////////////////////////////////////////////
	// derived conditions

	// clamp into accepted range
	function automatic logic [15:0] sfb_clamp(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic [15:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction : sfb_clamp

	// cap current, constant divisor
	always_comb begin
		cap_product = {7'h00, st.rated_cur} * st.tq_cap[6:0];
		cap_current = 16'(cap_product / sfb_pkg::TQ_CAP_SCALE);
	end

	// marker source, write range check
	always_comb begin
		// window wraps around angle zero
		index_win = (mech_angle <= sfb_pkg::INDEX_HALF_WIN) ||
			(mech_angle >= (16'h0000 - sfb_pkg::INDEX_HALF_WIN));
		speed_fast = st.ctrl[sfb_pkg::CTRL_SERIAL] &&
			(motor_speed_rpm > sfb_pkg::INDEX_SPEED_MAX);
		if (st.ctrl[sfb_pkg::CTRL_SERIAL]) begin
			index_raw = index_win;
		end else begin
			index_raw = st.idx_sync[1];
		end
		range_hit = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				sfb_pkg::ADDR_VEL_GAIN: range_hit = reg_wdata !=
					sfb_clamp(reg_wdata, sfb_pkg::VEL_GAIN_MIN,
					sfb_pkg::VEL_GAIN_MAX);
				sfb_pkg::ADDR_VEL_ITIME: range_hit =
					reg_wdata > sfb_pkg::VEL_ITIME_MAX;
				sfb_pkg::ADDR_TQ_FILT: range_hit =
					reg_wdata > sfb_pkg::TQ_FILT_MAX;
				sfb_pkg::ADDR_CUR_BW: range_hit = reg_wdata !=
					sfb_clamp(reg_wdata, sfb_pkg::CUR_BW_MIN,
					sfb_pkg::CUR_BW_MAX);
				sfb_pkg::ADDR_TQ_CAP: range_hit = reg_wdata !=
					sfb_clamp(reg_wdata, sfb_pkg::TQ_CAP_MIN,
					sfb_pkg::TQ_CAP_MAX);
				default: range_hit = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		// pins pass two flops before use
		next_st.idx_sync = {st.idx_sync[0], enc_index_in};
		next_st.sel_sync = {st.sel_sync[0], torque_cap_select_in};

		// writes; out-of-range values clamp to nearest end
		if (reg_wr) begin
			case (reg_addr)
				sfb_pkg::ADDR_CTRL: next_st.ctrl = reg_wdata[6:0];
				sfb_pkg::ADDR_GEAR_NUM: next_st.gear_num = reg_wdata;
				sfb_pkg::ADDR_GEAR_DEN: next_st.gear_den = reg_wdata;
				sfb_pkg::ADDR_VEL_GAIN: begin
					next_st.vel_gain = sfb_clamp(reg_wdata,
						sfb_pkg::VEL_GAIN_MIN, sfb_pkg::VEL_GAIN_MAX);
				end
				sfb_pkg::ADDR_VEL_ITIME: begin
					next_st.vel_itime = sfb_clamp(reg_wdata, 16'h0000,
						sfb_pkg::VEL_ITIME_MAX);
				end
				sfb_pkg::ADDR_TQ_FILT: begin
					next_st.tq_filt = sfb_clamp(reg_wdata, 16'h0000,
						sfb_pkg::TQ_FILT_MAX);
				end
				sfb_pkg::ADDR_CUR_BW: begin
					next_st.cur_bw = sfb_clamp(reg_wdata,
						sfb_pkg::CUR_BW_MIN, sfb_pkg::CUR_BW_MAX);
				end
				sfb_pkg::ADDR_TQ_CAP: begin
					next_st.tq_cap = sfb_clamp(reg_wdata,
						sfb_pkg::TQ_CAP_MIN, sfb_pkg::TQ_CAP_MAX);
				end
				sfb_pkg::ADDR_RATED_CUR: next_st.rated_cur = reg_wdata;
				sfb_pkg::ADDR_IRQ_EN: next_st.irq_en = reg_wdata[3:0];
				default: begin
					// status, clear, unmapped: no store
				end
			endcase
		end

		// read data stands one cycle
		next_st.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				sfb_pkg::ADDR_CTRL: next_st.rdata = {9'h000, st.ctrl};
				sfb_pkg::ADDR_GEAR_NUM: next_st.rdata = st.gear_num;
				sfb_pkg::ADDR_GEAR_DEN: next_st.rdata = st.gear_den;
				sfb_pkg::ADDR_VEL_GAIN: next_st.rdata = st.vel_gain;
				sfb_pkg::ADDR_VEL_ITIME: next_st.rdata = st.vel_itime;
				sfb_pkg::ADDR_TQ_FILT: next_st.rdata = st.tq_filt;
				sfb_pkg::ADDR_CUR_BW: next_st.rdata = st.cur_bw;
				sfb_pkg::ADDR_TQ_CAP: next_st.rdata = st.tq_cap;
				sfb_pkg::ADDR_RATED_CUR: next_st.rdata = st.rated_cur;
				sfb_pkg::ADDR_STATUS: begin
					next_st.rdata = {11'h000, speed_fast, st.fz,
						st.sel_sync[1], st.cap_flag,
						st.ctrl[sfb_pkg::CTRL_EN]};
				end
				sfb_pkg::ADDR_IRQ_STAT: next_st.rdata = {12'h000, st.irq_stat};
				sfb_pkg::ADDR_IRQ_EN: next_st.rdata = {12'h000, st.irq_en};
				default: next_st.rdata = 16'h0000;
			endcase
		end

		// feedback outputs; disabled pairs idle at logical low
		if (st.ctrl[sfb_pkg::CTRL_EN]) begin
			next_st.fa = fmt_a ^ st.ctrl[sfb_pkg::CTRL_NEG];
			next_st.fb = fmt_b ^ st.ctrl[sfb_pkg::CTRL_NEG];
			next_st.fz = index_raw ^ st.ctrl[sfb_pkg::CTRL_NEG];
		end else begin
			next_st.fa = st.ctrl[sfb_pkg::CTRL_NEG];
			next_st.fb = st.ctrl[sfb_pkg::CTRL_NEG];
			next_st.fz = st.ctrl[sfb_pkg::CTRL_NEG];
		end
		// complements from same next value, no skew
		next_st.fa_n = !next_st.fa;
		next_st.fb_n = !next_st.fb;
		next_st.fz_n = !next_st.fz;

		// clamp only while select is on
		next_st.tq_out = torque_cmd_in;
		if (st.sel_sync[1]) begin
			if (torque_cmd_in > $signed({1'b0, cap_current[14:0]})) begin
				next_st.tq_out = $signed({1'b0, cap_current[14:0]});
			end else if (torque_cmd_in <
				-$signed({1'b0, cap_current[14:0]})) begin
				next_st.tq_out = -$signed({1'b0, cap_current[14:0]});
			end
		end
		// measured current against cap
		next_st.cap_flag = torque_current >= cap_current;

		// edge events set sticky bits; a set beats a same-cycle clear
		next_st.idx_prev = index_raw;
		next_st.cap_prev = st.cap_flag;
		next_st.fast_prev = speed_fast;
		if (reg_wr && (reg_addr == sfb_pkg::ADDR_IRQ_CLR)) begin
			next_st.irq_stat = st.irq_stat & ~reg_wdata[3:0];
		end
		next_st.irq_stat = next_st.irq_stat | events;
		next_st.irq = |(next_st.irq_stat & st.irq_en);
	end

	// event pulses, one per rising condition, and one per clamped write
	always_comb begin
		events = 4'h0;
		events[sfb_pkg::IRQ_CAP] = st.cap_flag && !st.cap_prev;
		events[sfb_pkg::IRQ_INDEX] = index_raw && !st.idx_prev;
		events[sfb_pkg::IRQ_FAST] = speed_fast && !st.fast_prev;
		events[sfb_pkg::IRQ_RANGE] = range_hit;
	end

	////////////////////////////////////////////////////////////////////
	// state register

	// constants only; settings at defaults
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.ctrl <= sfb_pkg::CTRL_RESET;
			st.gear_num <= sfb_pkg::GEAR_RESET;
			st.gear_den <= sfb_pkg::GEAR_RESET;
			st.vel_gain <= sfb_pkg::VEL_GAIN_RESET;
			st.vel_itime <= sfb_pkg::VEL_ITIME_RESET;
			st.tq_filt <= sfb_pkg::TQ_FILT_RESET;
			st.cur_bw <= sfb_pkg::CUR_BW_RESET;
			st.tq_cap <= sfb_pkg::TQ_CAP_RESET;
			st.rated_cur <= sfb_pkg::RATED_CUR_RESET;
			st.fa_n <= 1'b1;
			st.fb_n <= 1'b1;
			st.fz_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign reg_rdata = st.rdata;
	assign torque_cmd_out = st.tq_out;
	assign torque_capping_flag_out = st.cap_flag;
	assign feedback_channel_a = st.fa;
	assign feedback_channel_a_n = st.fa_n;
	assign feedback_channel_b = st.fb;
	assign feedback_channel_b_n = st.fb_n;
	assign feedback_index_marker = st.fz;
	assign feedback_index_marker_n = st.fz_n;
	assign velocity_loop_gain = st.vel_gain;
	assign velocity_integral_time = st.vel_itime;
	assign torque_cmd_filter_time = st.tq_filt;
	assign current_loop_bandwidth = st.cur_bw;
	assign irq = st.irq;
endmodule : sfb_top
`default_nettype wire

// file: bench/sfb_top_properties.sv
// port checks for the feedback pulse and torque cap block
`timescale 1ns/1ps
`default_nettype none
module sfb_top_properties (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [15:0] mech_angle,
	input wire logic enc_index_in,
	input wire logic torque_cap_select_in,
	input wire logic [15:0] torque_current,
	input wire logic signed [15:0] torque_cmd_in,
	input wire logic signed [15:0] torque_cmd_out,
	input wire logic torque_capping_flag_out,
	input wire logic feedback_channel_a,
	input wire logic feedback_channel_a_n,
	input wire logic feedback_channel_b,
	input wire logic feedback_channel_b_n,
	input wire logic feedback_index_marker,
	input wire logic feedback_index_marker_n,
	input wire logic [15:0] velocity_loop_gain,
	input wire logic [15:0] velocity_integral_time,
	input wire logic [15:0] torque_cmd_filter_time,
	input wire logic [15:0] current_loop_bandwidth
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////
	logic [6:0] ctrl_sh; // copy of the control word
	logic [15:0] cap_sh; // cap factor as stored
	logic [2:0] age; // cycles since ctrl write
	logic [15:0] lim; // cap current at reset rated current
	logic en, neg, ser, win;
	logic [1:0] fmt;
	assign en = ctrl_sh[sfb_pkg::CTRL_EN];
	assign neg = ctrl_sh[sfb_pkg::CTRL_NEG];
	assign ser = ctrl_sh[sfb_pkg::CTRL_SERIAL];
	assign fmt = ctrl_sh[1:0];
	assign lim = cap_sh * 16'h000A;
	// negation folds the window around home
	assign win = 16'(-mech_angle) <= sfb_pkg::INDEX_HALF_WIN ||
		mech_angle <= sfb_pkg::INDEX_HALF_WIN;
	// shadows of software writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_sh <= sfb_pkg::CTRL_RESET;
			cap_sh <= sfb_pkg::TQ_CAP_RESET;
			age <= 3'h0;
		end else begin
			if (age != 3'h7) age <= age + 3'h1;
			if (reg_wr && reg_addr == sfb_pkg::ADDR_CTRL) begin
				ctrl_sh <= reg_wdata[6:0];
				age <= 3'h0;
			end
			if (reg_wr && reg_addr == sfb_pkg::ADDR_TQ_CAP) begin
				if (reg_wdata < sfb_pkg::TQ_CAP_MIN) cap_sh <= sfb_pkg::TQ_CAP_MIN;
				else if (reg_wdata > sfb_pkg::TQ_CAP_MAX) cap_sh <= sfb_pkg::TQ_CAP_MAX;
				else cap_sh <= reg_wdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_pairs;
		feedback_channel_a_n == !feedback_channel_a &&
		feedback_channel_b_n == !feedback_channel_b &&
		feedback_index_marker_n == !feedback_index_marker;
	endproperty
	a_pairs: assert property (p_pairs) else $error("pair not complementary");
	property p_quad_step;
		en && fmt == sfb_pkg::FMT_QUAD && age > 3'h3 |->
		!($changed(feedback_channel_a) && $changed(feedback_channel_b));
	endproperty
	a_quad_step: assert property (p_quad_step) else $error("a and b moved together");
	property p_disabled;
		!en && age > 3'h3 |-> feedback_channel_a == neg &&
		feedback_channel_b == neg && feedback_index_marker == neg;
	endproperty
	a_disabled: assert property (p_disabled) else $error("output while disabled");
	property p_pulse;
		en && !neg && (fmt == sfb_pkg::FMT_PULSE_SIGN ||
		fmt == sfb_pkg::FMT_FWD_REV) && age > 3'h3 |->
		!(feedback_channel_a && $past(feedback_channel_a));
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse wider than one cycle");
	property p_idx_inc;
		en && !ser && age > 3'h3 |->
		feedback_index_marker == ($past(enc_index_in, 3) ^ neg);
	endproperty
	a_idx_inc: assert property (p_idx_inc) else $error("index not passed");
	property p_idx_ser;
		en && ser && age > 3'h3 |-> feedback_index_marker == ($past(win) ^ neg);
	endproperty
	a_idx_ser: assert property (p_idx_ser) else $error("marker off window");
	property p_flag;
		torque_capping_flag_out == ($past(torque_current) >= $past(lim));
	endproperty
	a_flag: assert property (p_flag) else $error("cap flag wrong");
	property p_pass;
		(!torque_cap_select_in) [*5] |-> torque_cmd_out == $past(torque_cmd_in);
	endproperty
	a_pass: assert property (p_pass) else $error("torque clamped while off");
	property p_ranges;
		velocity_loop_gain >= sfb_pkg::VEL_GAIN_MIN &&
		velocity_loop_gain <= sfb_pkg::VEL_GAIN_MAX &&
		velocity_integral_time <= sfb_pkg::VEL_ITIME_MAX &&
		torque_cmd_filter_time <= sfb_pkg::TQ_FILT_MAX &&
		current_loop_bandwidth >= sfb_pkg::CUR_BW_MIN;
	endproperty
	a_ranges: assert property (p_ranges) else $error("setting out of range");
endmodule : sfb_top_properties
bind sfb_top sfb_top_properties u_props (.*);
`default_nettype wire

// file: bench/sfb_host_model.sv
// host side: decodes the feedback pairs
`timescale 1ns/1ps
`default_nettype none
module sfb_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic a,
	input wire logic a_n,
	input wire logic b,
	input wire logic b_n,
	output logic signed [15:0] pos,
	output logic [15:0] a_rises,
	output logic [15:0] b_rises,
	output logic pair_err
);
	logic pa, pb; // line levels one cycle back
	// same logic sense as the block
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{pa, pb, pair_err} <= 3'h0;
			pos <= 16'sh0000;
			a_rises <= 16'h0000;
			b_rises <= 16'h0000;
		end else begin
			pa <= a;
			pb <= b;
			if (a && !pa) a_rises <= a_rises + 16'h0001;
			if (b && !pb) b_rises <= b_rises + 16'h0001;
			// one line moving counts; b leading is up
			if ((a != pa) ^ (b != pb)) pos <= (a ^ pb) ? pos - 16'sd1 : pos + 16'sd1;
			if (a_n == a || b_n == b) pair_err <= 1'b1;
		end
	end
endmodule : sfb_host_model
`default_nettype wire

// file: bench/tb_servo_feedback_pulse_and_torque_limit.sv
// self-checking testbench for the feedback pulse and torque cap block
`timescale 1ns/1ps
`default_nettype none
module tb_servo_feedback_pulse_and_torque_limit;
	logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, motor_step = 0;
	logic motor_dir = 0, enc_index_in = 0, torque_cap_select_in = 0;
	logic [3:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, mech_angle = 0, motor_speed_rpm = 0;
	logic [15:0] torque_current = 0, reg_rdata, gain, itime, filt, bw;
	logic signed [15:0] torque_cmd_in = 0, torque_cmd_out, pos;
	logic [15:0] a_rises, b_rises;
	logic flag, fa, fan, fb, fbn, fz, fzn, irq, pair_err;
	int err_count = 0, n_checks = 0;
	////////////////////////////////////////////////////////////////////////
	always #50 clk = ~clk; // 10 MHz
	sfb_top dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .motor_step, .motor_dir, .mech_angle, .motor_speed_rpm,
		.enc_index_in, .torque_cap_select_in, .torque_current, .torque_cmd_in,
		.torque_cmd_out, .torque_capping_flag_out(flag),
		.feedback_channel_a(fa), .feedback_channel_a_n(fan),
		.feedback_channel_b(fb), .feedback_channel_b_n(fbn),
		.feedback_index_marker(fz), .feedback_index_marker_n(fzn),
		.velocity_loop_gain(gain), .velocity_integral_time(itime),
		.torque_cmd_filter_time(filt), .current_loop_bandwidth(bw), .irq);
	sfb_host_model u_host (.clk, .rstn, .a(fa), .a_n(fan), .b(fb),
		.b_n(fbn), .pos, .a_rises, .b_rises, .pair_err);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data checked in its one cycle
	task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		cyc(1);
		reg_rd <= 1'b0;
		chk(reg_rdata & m, e);
	endtask : rd
	// spaced steps, the throttle never queues
	task automatic steps(input int n, input logic d);
		repeat (n) begin
			@(posedge clk);
			{motor_step, motor_dir} <= {1'b1, d};
			@(posedge clk);
			motor_step <= 1'b0;
			repeat (6) @(posedge clk);
		end
		cyc(6);
	endtask : steps
	// clamp with cap 0.50 of 1000 rated
	function automatic logic [15:0] tq_exp(logic signed [15:0] c, logic s);
		if (s && c > 500) return 16'sd500;
		if (s && c < -500) return -16'sd500;
		return c;
	endfunction : tq_exp
	task automatic end_of_test;
		if (err_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		err_count++;
		end_of_test();
	end
	initial begin
		logic [3:0] ta [7] = '{3, 3, 4, 5, 6, 7, 7};
		logic [15:0] tw [7] = '{5, 16'hFFFF, 2000, 16'h8000, 100, 0, 100};
		logic [15:0] te [7] = '{10, 10000, 1000, 32767, 500, 1, 70};
		logic [15:0] ang [4] = '{91, 92, 16'hFFA5, 16'hFFA4};
		logic [15:0] v, r0, q0;
		logic signed [15:0] c;
		int d;
		v = $urandom(1);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(sfb_pkg::ADDR_VEL_GAIN, 16'h0064, 16'hFFFF);
		rd(sfb_pkg::ADDR_TQ_CAP, 16'h0046, 16'hFFFF);
		rd(sfb_pkg::ADDR_CUR_BW, 16'h07D0, 16'hFFFF);
		// clamped writes raise the range event
		wr(sfb_pkg::ADDR_IRQ_EN, 16'h0008);
		for (int i = 0; i < 7; i++) begin
			wr(ta[i], tw[i]);
			rd(ta[i], te[i], 16'hFFFF);
		end
		chk({15'h0, irq}, 16'h0001);
		wr(sfb_pkg::ADDR_IRQ_CLR, 16'h0008);
		wr(sfb_pkg::ADDR_IRQ_EN, 16'h0000);
		wr(sfb_pkg::ADDR_VEL_GAIN, 16'h0000);
		rd(sfb_pkg::ADDR_IRQ_STAT, 16'h0008, 16'h0008);
		chk({15'h0, irq}, 16'h0000);
		wr(4'hD, 16'h1234);
		rd(4'hD, 16'h0000, 16'hFFFF);
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom_range(10000, 10));
			wr(sfb_pkg::ADDR_VEL_GAIN, v);
			rd(sfb_pkg::ADDR_VEL_GAIN, v, 16'hFFFF);
			chk(gain, v);
		end
		// cap 0.50: boundaries, then random
		wr(sfb_pkg::ADDR_TQ_CAP, 16'h0032);
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk);
			torque_cap_select_in <= s[0];
			cyc(5);
			for (int i = 0; i < 12; i++) begin
				c = (i == 0) ? 16'sd501 : 16'($urandom_range(4000) - 2000);
				v = (i == 0) ? 500 : (i == 1) ? 499 : 16'($urandom_range(1000));
				@(posedge clk);
				{torque_cmd_in, torque_current} <= {c, v};
				cyc(2);
				chk(torque_cmd_out, tq_exp(c, s[0]));
				chk({15'h0, flag}, {15'h0, v >= 500});
			end
		end
		// quadrature at gear 1/4
		wr(sfb_pkg::ADDR_GEAR_NUM, 16'h0001);
		wr(sfb_pkg::ADDR_GEAR_DEN, 16'h0004);
		r0 = pos;
		steps(40, 1'b1);
		d = int'(pos) - int'(signed'(r0)) - 10;
		chk({15'h0, d >= -1 && d <= 1}, 16'h0001);
		steps(40, 1'b0);
		d = int'(pos) - int'(signed'(r0));
		chk({15'h0, d >= -1 && d <= 1}, 16'h0001);
		// pulse/sign, then fwd/rev, gear 1/1
		wr(sfb_pkg::ADDR_GEAR_DEN, 16'h0001);
		wr(sfb_pkg::ADDR_CTRL, 16'h0021);
		r0 = a_rises;
		steps(8, 1'b1);
		chk(a_rises - r0, 16'h0008);
		chk({15'h0, fb}, 16'h0001);
		steps(3, 1'b0);
		chk({15'h0, fb}, 16'h0000);
		wr(sfb_pkg::ADDR_CTRL, 16'h0022);
		r0 = a_rises;
		q0 = b_rises;
		steps(5, 1'b1);
		steps(4, 1'b0);
		chk(a_rises - r0, 16'h0005);
		chk(b_rises - q0, 16'h0004);
		// disabled lines idle at logical zero
		wr(sfb_pkg::ADDR_CTRL, 16'h0000);
		r0 = a_rises;
		steps(6, 1'b1);
		chk(a_rises - r0, 16'h0000);
		wr(sfb_pkg::ADDR_CTRL, 16'h0010);
		cyc(5);
		chk({13'h0, fa, fb, fz}, 16'h0007);
		// index: incremental, serial window, speed bound
		wr(sfb_pkg::ADDR_CTRL, 16'h0020);
		@(posedge clk);
		enc_index_in <= 1'b1;
		cyc(5);
		chk({15'h0, fz}, 16'h0001);
		wr(sfb_pkg::ADDR_CTRL, 16'h0060);
		for (int i = 0; i < 34; i++) begin
			@(posedge clk);
			mech_angle <= (i < 4) ? ang[i] : 16'($urandom);
			cyc(2);
			if (i < 4) chk({15'h0, fz}, {15'h0, ~i[0]});
		end
		@(posedge clk);
		motor_speed_rpm <= 16'd101;
		rd(sfb_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
		@(posedge clk);
		motor_speed_rpm <= 16'd100;
		cyc(3);
		rd(sfb_pkg::ADDR_STATUS, 16'h0000, 16'h0010);
		chk({15'h0, pair_err}, 16'h0000);
		end_of_test();
	end
endmodule : tb_servo_feedback_pulse_and_torque_limit
`default_nettype wire
